//--- rtl/lcf_map.vh
// Constants for the line clock flag unit
`ifndef LCF_MAP_VH
`define LCF_MAP_VH

// Register byte offsets
`define LCF_CMD_OFS 4'h0
`define LCF_STAT_OFS 4'h4
`define LCF_RATE_OFS 4'h8

// Instruction word fields
`define LCF_OP_MSB 11
`define LCF_OP_LSB 9
`define LCF_OP_IOT 3'h6
`define LCF_DEV_HI_MSB 8
`define LCF_DEV_HI_LSB 6
`define LCF_DEV_HI 3'h4
`define LCF_DEV_LO_MSB 5
`define LCF_DEV_LO_LSB 3
`define LCF_DEV_LO_BASE 3'h2
`define LCF_FN_TEST 0
`define LCF_FN_OFF 1
`define LCF_FN_ON 2

// Status register fields
`define LCF_ST_FLAG_LSB 0
`define LCF_ST_EN_LSB 4
`define LCF_ST_IRQ 8

// Reset values
`define LCF_RATE_RST 8'hE4
`define LCF_FLAG_RST 4'h0
`define LCF_EN_RST 4'h0

// Tick intervals in microseconds, one per crystal
`define LCF_CLK_MHZ 250
`define LCF_T110_US 1136
`define LCF_T75_US 1665
`define LCF_T50_US 2500
`define LCF_T45_US 2780
// Cycle counts are microseconds times 250, sized to the 20-bit dividers
`define LCF_T110_CYC 20'h4_5560
`define LCF_T75_CYC 20'h6_59fa
`define LCF_T50_CYC 20'h9_8968
`define LCF_T45_CYC 20'ha_9ad8

`endif

//--- rtl/lcf_unit.v
// Four line clocks with skip, enable and flag control over Avalon-MM
// Contract
// RULE1: Test instruction skips only when the addressed clock flag is set.
// RULE2: Turn-on clears the flag and enables the clock; the code sets the flag instead if a tick lands in the same cycle.
// RULE3: Turn-off clears the flag and disables the clock.
// RULE4: Clocks one to four decode on digits 2-5; functions 1,2,4.
// RULE5: 110 baud ticks every 1136 us; 75 baud every 1665 us.
// RULE6: 50 baud every 2500 us; 45 baud every 2780 us; within 1 percent.
// RULE7: Enabled clock sets flag and interrupts within 4 ms.
// RULE8: Disabled clock raises no interrupt while it stays disabled.
// RULE9: Only enabled clocks may set flags or request interrupts.
// RULE10: Each clock holds enable and flag independently.
// RULE11: Flag stays set until cleared; interrupt is OR of flags.
// RULE12: Reset disables all clocks and clears all flags.
`timescale 1ns/10ps
`include "lcf_map.vh"

module lcf_unit #(
    parameter [19:0] T110_CYC = `LCF_T110_CYC,
    parameter [19:0] T75_CYC = `LCF_T75_CYC,
    parameter [19:0] T50_CYC = `LCF_T50_CYC,
    parameter [19:0] T45_CYC = `LCF_T45_CYC
) (
    // Clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // Avalon-MM slave
    input wire [3:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    output wire [31:0] readdata_o,
    output wire waitrequest_o,
    // Interrupt request to the host
    output wire irq_o
);

    reg wait_ff;
    reg [31:0] rdata_ff;
    reg irq_ff;
    reg skip_ff;
    reg [7:0] rate_ff;
    reg [3:0] flag_ff;
    reg [3:0] en_ff;
    wire [3:0] nxt_flag;
    wire [3:0] nxt_en;
    wire [3:0] test_hit;
    wire acc;
    wire wr_cmd;
    wire op_ok;

    // One access completes per two cycles; wait drops for one edge only
    assign acc = (read_i | write_i) & ~wait_ff;
    assign wr_cmd = write_i & ~wait_ff & (address_i == `LCF_CMD_OFS);
    assign op_ok = (writedata_i[`LCF_OP_MSB:`LCF_OP_LSB] == `LCF_OP_IOT) &
        (writedata_i[`LCF_DEV_HI_MSB:`LCF_DEV_HI_LSB] == `LCF_DEV_HI); // [RULE4]

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_clk
            reg [19:0] cnt_ff;
            reg [19:0] nxt_cnt;
            reg [19:0] period;
            wire sel;
            wire clr;
            wire tick;
            localparam [2:0] DEV_CODE = `LCF_DEV_LO_BASE + i;

            // Device digit is base plus clock index
            assign sel = wr_cmd & op_ok &
                (writedata_i[`LCF_DEV_LO_MSB:`LCF_DEV_LO_LSB] == DEV_CODE); // [RULE4]
            assign clr = sel & (writedata_i[`LCF_FN_ON] | writedata_i[`LCF_FN_OFF]); // [RULE2] [RULE3]
            assign test_hit[i] = sel & writedata_i[`LCF_FN_TEST] & flag_ff[i]; // [RULE1]

            // On wins if both function bits are given
            assign nxt_en[i] = (sel & writedata_i[`LCF_FN_ON]) ? 1'b1 :
                (sel & writedata_i[`LCF_FN_OFF]) ? 1'b0 : en_ff[i]; // [RULE2] [RULE3] [RULE10]

            always @* begin
                case (rate_ff[2*i+1:2*i])
                    2'h0: period = T110_CYC; // [RULE5]
                    2'h1: period = T75_CYC; // [RULE5]
                    2'h2: period = T50_CYC; // [RULE6]
                    default: period = T45_CYC; // [RULE6]
                endcase
            end

            // Restart on turn-on so the first tick lands one full period later
            assign tick = en_ff[i] & (cnt_ff == 20'h0_0000);
            always @* begin
                if (!nxt_en[i] || (sel && writedata_i[`LCF_FN_ON])) begin
                    nxt_cnt = period - 20'h0_0001; // [RULE7]
                end else if (tick) begin
                    nxt_cnt = period - 20'h0_0001; // [RULE5] [RULE6]
                end else begin
                    nxt_cnt = cnt_ff - 20'h0_0001;
                end
            end

            // Tick beats a clear in the same cycle, but never while disabled
            assign nxt_flag[i] = nxt_en[i] & (tick | (flag_ff[i] & ~clr)); // [RULE9] [RULE11] [RULE8]

            always @(posedge core_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    cnt_ff <= 20'h0_0000;
                end else begin
                    cnt_ff <= nxt_cnt;
                end
            end
        end
    endgenerate

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_ff <= `LCF_FLAG_RST; // [RULE12]
            en_ff <= `LCF_EN_RST; // [RULE12]
            irq_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            en_ff <= nxt_en;
            irq_ff <= |nxt_flag; // [RULE11] [RULE10]
        end
    end

    // Bus side
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            skip_ff <= 1'b0;
            rate_ff <= `LCF_RATE_RST;
        end else begin
            wait_ff <= ~((read_i | write_i) & wait_ff);
            if (wr_cmd) begin
                skip_ff <= |test_hit; // [RULE1]
            end
            if (write_i && !wait_ff && address_i == `LCF_RATE_OFS) begin
                rate_ff <= writedata_i[7:0];
            end
            if ((read_i | write_i) && wait_ff && read_i) begin
                case (address_i)
                    `LCF_CMD_OFS: rdata_ff <= {31'h0000_0000, skip_ff};
                    `LCF_STAT_OFS: rdata_ff <= {23'h00_0000, irq_ff, en_ff, flag_ff};
                    `LCF_RATE_OFS: rdata_ff <= {24'h00_0000, rate_ff};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end else if (acc) begin
                rdata_ff <= rdata_ff;
            end
        end
    end

    assign readdata_o = rdata_ff;
    assign waitrequest_o = wait_ff;
    assign irq_o = irq_ff;

endmodule // lcf_unit

//--- bench/lcf_host.sv
// Host model issuing instruction words over Avalon-MM
`timescale 1ns/10ps
module lcf_host (
    input wire core_clk_i,
    input wire waitrequest_o,
    input wire [31:0] readdata_o,
    output logic [3:0] address_i = 4'h0,
    output logic read_i = 0,
    output logic write_i = 0,
    output logic [31:0] writedata_i = 32'h0000_0000
);
    // Request held until waitrequest drops, so no access is lost
    task acc(input w, input [3:0] a, input [31:0] d, output [31:0] q);
        @(posedge core_clk_i);
        address_i <= a;
        writedata_i <= d;
        read_i <= !w;
        write_i <= w;
        do @(posedge core_clk_i); while (waitrequest_o);
        q = readdata_o;
        read_i <= 0;
        write_i <= 0;
    endtask
endmodule // lcf_host

//--- bench/lcf_unit_sva.sv
// Bus and interrupt checks for the line clock unit
`timescale 1ns/10ps
module lcf_unit_sva (
    input wire core_clk_i, input wire reset_i, input wire [3:0] address_i, input wire read_i,
    input wire write_i, input wire [31:0] writedata_i, input wire [31:0] readdata_o,
    input wire waitrequest_o, input wire irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire ack = !waitrequest_o;
    wire rak = read_i && ack;
    wire cmd_wr = write_i && ack && address_i == 4'h0;
    bus_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> ack) else $error("no answer");
    answer_once_a: assert property (ack |=> waitrequest_o) else $error("long answer");
    reset_quiet_a: assert property ($fell(reset_i) |-> !irq_o && waitrequest_o) else $error("reset");
    irq_sticky_a: assert property (irq_o && !cmd_wr |=> irq_o) else $error("irq dropped");
    irq_or_a: assert property (rak && address_i == 4'h4 |-> readdata_o[8] == |readdata_o[3:0]) else $error("or");
    flag_enabled_a: assert property (rak && address_i == 4'h4 |-> !(readdata_o[3:0] & ~readdata_o[7:4]))
        else $error("flag");
    skip_bit_a: assert property (rak && address_i == 4'h0 |-> readdata_o[31:1] == 0) else $error("skip");
    unmapped_zero_a: assert property (rak && address_i == 4'hc |-> readdata_o == 0) else $error("unmapped");
endmodule // lcf_unit_sva
bind lcf_unit lcf_unit_sva chk (.core_clk_i, .reset_i, .address_i, .read_i, .write_i, .writedata_i,
    .readdata_o, .waitrequest_o, .irq_o);

//--- bench/tb_lcf_unit.sv
// Testbench for the line clock unit
`timescale 1ns/10ps
module tb_lcf_unit;
    logic core_clk_i = 0, reset_i = 1, read_i, write_i, waitrequest_o, irq_o;
    logic [3:0] address_i;
    logic [31:0] writedata_i, readdata_o, q;
    int miscompares = 0, num_checks = 0, cyc = 0, k;
    always #2 core_clk_i = ~core_clk_i;
    // Short periods stand for the crystal counts
    lcf_unit #(.T110_CYC(40), .T75_CYC(60), .T50_CYC(80), .T45_CYC(100)) dut (.core_clk_i, .reset_i,
        .address_i, .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o, .irq_o);
    lcf_host host (.core_clk_i, .waitrequest_o, .readdata_o, .address_i, .read_i, .write_i, .writedata_i);
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        host.acc(0, a, 0, q);
        chk(q, e);
    endtask
    function [31:0] cw(input [2:0] n, input [2:0] f);
        return {20'h0_0000, 6'h34, n + 3'h2, f};
    endfunction
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        reset_i <= 0;
        rd(4'h4, 32'h0000_0000);
        rd(4'h8, 32'h0000_00e4);
        rd(4'hc, 32'h0000_0000);
        for (int n = 0; n < 4; n++) begin
            host.acc(1, 0, cw(n[2:0], 4), q);
            for (k = 0; !irq_o && k < 300; k++) @(posedge core_clk_i);
            chk(k >= 40 + 20 * n && k <= 41 + 20 * n, 1);
            host.acc(1, 0, cw(n[2:0], 1), q);
            rd(4'h0, 32'h0000_0001);
            rd(4'h4, 32'h0000_0100 | 32'h0000_0011 << n);
            host.acc(1, 0, cw(n[2:0], 2), q);
            host.acc(1, 0, cw(n[2:0], 1), q);
            rd(4'h0, 32'h0000_0000);
            repeat (250) @(posedge core_clk_i);
            rd(4'h4, 32'h0000_0000);
        end
        host.acc(1, 4'h8, 32'h0000_001b, q);
        rd(4'h8, 32'h0000_001b);
        host.acc(1, 4'h4, 32'hffff_ffff, q);
        host.acc(1, 4'hc, 32'hffff_ffff, q);
        rd(4'h4, 32'h0000_0000);
        rd(4'hc, 32'h0000_0000);
        host.acc(1, 0, cw(0, 4), q);
        host.acc(1, 0, cw(2, 4), q);
        repeat (120) @(posedge core_clk_i);
        rd(4'h4, 32'h0000_0155);
        host.acc(1, 0, cw(0, 2), q);
        rd(4'h4, 32'h0000_0144);
        host.acc(1, 0, cw(1, 6), q);
        rd(4'h4, 32'h0000_0164);
        @(posedge core_clk_i) reset_i <= 1;
        repeat (5) @(posedge core_clk_i);
        reset_i <= 0;
        rd(4'h4, 32'h0000_0000);
        rd(4'h8, 32'h0000_00e4);
        report_and_stop;
    end
endmodule // tb_lcf_unit
